// ==== tcfs_clock_sync_select.sv ====
// Clock and frame sync source selection, polarity and first bit delay
// Register map
//   0x00 global: bit 0 rx enable, bit 1 tx enable,
//        bit 4 clock redundancy select
//   0x04 receive clock select, bit 0 source
//   0x08 transmit clock select, bit 0 source
//   0x0C receive channel config
//   0x10 transmit channel config
//   0x14 status, read only
//
// Channel config fields
//   bit 0       rate mode, 1 single-rate
//   bits 2:1    link rate, 11 reserved
//   bit 3       data edge, 1 rising
//   bit 4       sync edge, 1 rising
//   bit 7       sync level, 1 high
//   bits 29:16  first bit delay
//   Bits 7 and 29:16 hold while enabled
//
// Status fields
//   bit 0 rx locked, bit 1 tx locked
//   bit 4 rx source, bit 5 tx source
//
// Register bus
//   Writes land on the strobe edge
//   Read data stand one cycle, else zero
//   Strobes may come back to back
//   The bus never waits
//   Unmapped: reads zero, writes dropped
//
// Reset
//   Registers clear: pair A, double-rate,
//   8 Mbps, falling edges, sync low, delay 0
//   Events and lock clear; gate stands open
//
// Clock modes
//   Single-rate: one sample edge per bit
//   Double-rate: both edges are sample edges
//   Frame period: 1024 << rate sample edges,
//   doubled for a double-rate clock
//
// Source selection
//   Redundancy zero: both directions take
//   the tx source, mode and rate
//   Redundancy one: each uses its own
//   Pair A is source 0, pair B source 1
//
// Timing engine
//   Pins pass three flip-flops; a change
//   counts once stages two and three agree
//   Link half period: two core cycles min,
//   or edges are lost in the filter
//   Sync taken on its edge at its level,
//   registered, then the delay count starts
//   Delay counter counts both edges:
//     single-rate 2n+4 same, 2n+3 differing
//     double-rate n+2 same, n+3 differing
//   Double-rate has no half edge, so
//   differing polarities round up
//   A sync inside the period is dropped;
//   the period counter saturates
//   Recognition edge is the first period edge
//   Reserved rate is timed as the slowest
//   Source change or disable drops lock;
//   the next sync while enabled relocks
//
// Transfer walk, sync low on falling edge
//   Pin edge seen after three or four cycles
//   Next cycle: recognition registered
//   Next cycle: frame start pulse, lock set
//   Delay count on every later clock edge
//   First bit pulse on the target edge
//   Sample pulses on sample edges when locked
//
// Outputs
//   Events: registered pulses, 0 rx, 1 tx
//   Effective config is combinational
//   Lock is a level
//
// Hazards
//   A source switch loses lock until the next sync
//   Protected writes while enabled are ignored
//   Status shows effective sources
//
// Limitations
//   No frame size, superframe or buffering
//   No interrupts; software polls status
//   Shared mode: rx keeps edges, level, delay
//   Delay past a frame restarts on next sync
//
module tcfs_clock_sync_select
    import tcfs_pkg::*;
(
    input  wire logic          core_clk_in,
    input  wire logic          nrst_in,
    // Register port
    input  wire logic [7:0]    reg_addr_in,
    input  wire logic [31:0]   reg_wdata_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    output logic [31:0]        reg_rdata_out,
    // Backplane clock and frame sync pairs
    input  wire logic          serial_clock_a_in,
    input  wire logic          frame_sync_a_in,
    input  wire logic          serial_clock_b_in,
    input  wire logic          frame_sync_b_in,
    // Timing events, index 0 receive, index 1 transmit
    output tcfs_dir_evt_t [1:0] dir_evt_out,
    output tcfs_dir_cfg_t [1:0] dir_cfg_out
);

    // Configuration registers
    logic [31:0]   global_r;
    logic [31:0]   rx_clk_r;
    logic [31:0]   tx_clk_r;
    logic [31:0]   rx_cfg_r;
    logic [31:0]   tx_cfg_r;
    logic [31:0]   rdata_r;

    // Address decode
    wire           sel_global = (reg_addr_in == TCFS_OFS_GLOBAL);
    wire           sel_rx_clk = (reg_addr_in == TCFS_OFS_RX_CLK);
    wire           sel_tx_clk = (reg_addr_in == TCFS_OFS_TX_CLK);
    wire           sel_rx_cfg = (reg_addr_in == TCFS_OFS_RX_CFG);
    wire           sel_tx_cfg = (reg_addr_in == TCFS_OFS_TX_CFG);
    wire           sel_status = (reg_addr_in == TCFS_OFS_STATUS);
    wire           rx_en      = global_r[TCFS_BIT_RX_EN];
    wire           tx_en      = global_r[TCFS_BIT_TX_EN];
    wire           redund     = global_r[TCFS_BIT_REDUND];

    // Protected fields keep their value while the direction runs
    wire [31:0]    rx_keep = rx_en ? TCFS_MSK_LOCKED : 32'h0000_0000;
    wire [31:0]    tx_keep = tx_en ? TCFS_MSK_LOCKED : 32'h0000_0000;
    wire [31:0]    rx_cfg_nxt = (rx_cfg_r & rx_keep)
                              | (reg_wdata_in & TCFS_MSK_CHCFG & ~rx_keep);
    wire [31:0]    tx_cfg_nxt = (tx_cfg_r & tx_keep)
                              | (reg_wdata_in & TCFS_MSK_CHCFG & ~tx_keep);

    // Register writes; sources change only here, never on their own
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            global_r <= TCFS_RST_GLOBAL;
            rx_clk_r <= TCFS_RST_CLKSEL;
            tx_clk_r <= TCFS_RST_CLKSEL;
            rx_cfg_r <= TCFS_RST_CHCFG;
            tx_cfg_r <= TCFS_RST_CHCFG;
        end
        else if (reg_wr_in)
        begin
            if (sel_global)
                global_r <= reg_wdata_in & TCFS_MSK_GLOBAL;
            if (sel_rx_clk)
                rx_clk_r <= reg_wdata_in & TCFS_MSK_CLKSEL;
            if (sel_tx_clk)
                tx_clk_r <= reg_wdata_in & TCFS_MSK_CLKSEL;
            if (sel_rx_cfg)
                rx_cfg_r <= rx_cfg_nxt;
            if (sel_tx_cfg)
                tx_cfg_r <= tx_cfg_nxt;
        end
    end

    // Status word: lock per direction, active sources
    wire [31:0]    status_word = {26'h0, dir_cfg_out[1].source, dir_cfg_out[0].source,
                                  2'b00, dir_evt_out[1].locked, dir_evt_out[0].locked};

    // Read data selection
    wire [31:0]    rd_mux = sel_global ? global_r :
                            sel_rx_clk ? rx_clk_r :
                            sel_tx_clk ? tx_clk_r :
                            sel_rx_cfg ? rx_cfg_r :
                            sel_tx_cfg ? tx_cfg_r :
                            sel_status ? status_word : 32'h0000_0000;

    // Read data stand in the cycle after the strobe only
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rdata_r <= 32'h0000_0000;
        else
            rdata_r <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
    assign reg_rdata_out = rdata_r;

    // Decode one channel config word with a given source/mode/rate
    function automatic tcfs_dir_cfg_t make_cfg(input logic src, input logic [31:0] mr,
                                               input logic [31:0] own);
        tcfs_dir_cfg_t c;
        c.source   = src;
        c.single   = mr[TCFS_BIT_MODE];
        c.rate     = tcfs_rate_t'(mr[TCFS_POS_RATE +: 2]);
        c.data_pol = own[TCFS_BIT_DPOL];
        c.sync_pol = own[TCFS_BIT_FPOL];
        c.level    = own[TCFS_BIT_LEVEL];
        c.delay    = own[TCFS_POS_DELAY +: TCFS_W_DELAY];
        return c;
    endfunction

    // Effective selections: receive borrows the transmit choices unless dual mode
    tcfs_dir_cfg_t [1:0] eff_cfg;
    assign eff_cfg[1] = make_cfg(tx_clk_r[TCFS_BIT_SRC], tx_cfg_r, tx_cfg_r);
    assign eff_cfg[0] = redund
                      ? make_cfg(rx_clk_r[TCFS_BIT_SRC], rx_cfg_r, rx_cfg_r)
                      : make_cfg(tx_clk_r[TCFS_BIT_SRC], tx_cfg_r, rx_cfg_r);
    wire [1:0]     dir_en = {tx_en, rx_en};

    // Pin synchronisers: three stages, a change counts when stages two and three agree
    logic [3:0]    pin_s1_r;
    logic [3:0]    pin_s2_r;
    logic [3:0]    pin_s3_r;
    logic [3:0]    pin_f_r;
    wire  [3:0]    pin_raw = {frame_sync_b_in, serial_clock_b_in,
                              frame_sync_a_in, serial_clock_a_in};

    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
            pin_f_r  <= 4'h0;
        end
        else
        begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r  <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
        end
    end

    // Per-direction timing engine
    genvar d;
    generate
        for (d = 0; d < 2; d++)
        begin : g_dir
            logic                   clk_prev_r;
            logic                   recog_r;
            logic                   locked_r;
            logic                   counting_r;
            logic                   src_prev_r;
            logic [TCFS_CNT_W-1:0]  delay_cnt_r;
            logic [TCFS_CNT_W-1:0]  period_cnt_r;
            logic                   first_bit_r;
            logic                   frame_start_r;
            logic                   sample_r;

            // Selected pair: one source bit picks clock and sync together
            tcfs_dir_cfg_t c;
            assign c = eff_cfg[d];
            wire clk_sel  = c.source ? pin_f_r[2] : pin_f_r[0];
            wire sync_sel = c.source ? pin_f_r[3] : pin_f_r[1];
            wire rise     = clk_sel & ~clk_prev_r;
            wire fall     = ~clk_sel & clk_prev_r;
            wire any_edge = rise | fall;
            wire sync_edge = c.sync_pol ? rise : fall;
            wire data_edge = c.data_pol ? rise : fall;
            // Double-rate clock samples on both edges
            wire samp_edge = c.single ? data_edge : any_edge;
            wire pol_same  = (c.data_pol == c.sync_pol);

            // Frame period in sample edges; reserved rate acts as the slowest
            wire [1:0] rate_sh = (c.rate == TCFS_RATE_RSV) ? 2'b00 : c.rate;
            wire [TCFS_CNT_W-1:0] period = TCFS_CNT_W'(TCFS_FRAME_CLOCKS)
                                           << (rate_sh + {1'b0, ~c.single});
            wire gate_open = ~locked_r || (period_cnt_r >= period);

            // Sync sampled at its level on its edge
            wire sync_hit = sync_edge && (sync_sel == c.level);

            // Delay target in edges of either polarity
            wire [TCFS_CNT_W-1:0] n_ext = TCFS_CNT_W'(c.delay);
            wire [TCFS_CNT_W-1:0] target =
                c.single ? ((n_ext << 1) + (pol_same ? 16'h0004 : 16'h0003))
                         : (n_ext + (pol_same ? 16'h0002 : 16'h0003));
            wire cfg_change = (c.source != src_prev_r) || !dir_en[d];

            // Edge history, recognition and delay count
            always_ff @(posedge core_clk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    clk_prev_r    <= 1'b0;
                    src_prev_r    <= 1'b0;
                    recog_r       <= 1'b0;
                    locked_r      <= 1'b0;
                    counting_r    <= 1'b0;
                    delay_cnt_r   <= 16'h0000;
                    period_cnt_r  <= 16'h0000;
                    first_bit_r   <= 1'b0;
                    frame_start_r <= 1'b0;
                    sample_r      <= 1'b0;
                end
                else
                begin
                    clk_prev_r    <= clk_sel;
                    src_prev_r    <= c.source;
                    first_bit_r   <= 1'b0;
                    frame_start_r <= 1'b0;
                    // No sample pulse in the cycle that drops lock
                    sample_r      <= samp_edge & locked_r & ~cfg_change;
                    // Recognition registered before the delay count starts
                    recog_r       <= sync_hit & gate_open & dir_en[d];
                    if (cfg_change)
                    begin
                        // Switchover drops lock until the next accepted sync
                        locked_r   <= 1'b0;
                        counting_r <= 1'b0;
                        recog_r    <= 1'b0;
                    end
                    else if (recog_r)
                    begin
                        locked_r      <= 1'b1;
                        counting_r    <= 1'b1;
                        frame_start_r <= 1'b1;
                        delay_cnt_r   <= 16'h0000;
                        // Sync edge counts, so the next on-time sync passes
                        period_cnt_r  <= 16'h0001;
                    end
                    else
                    begin
                        if (samp_edge && period_cnt_r < period)
                            period_cnt_r <= period_cnt_r + 16'h0001;
                        // Every edge counts; a delay past a frame restarts on the next sync
                        if (counting_r && any_edge)
                        begin
                            if (delay_cnt_r + 16'h0001 == target)
                            begin
                                first_bit_r <= 1'b1;
                                counting_r  <= 1'b0;
                            end
                            else
                                delay_cnt_r <= delay_cnt_r + 16'h0001;
                        end
                    end
                end
            end

            assign dir_evt_out[d].locked      = locked_r;
            assign dir_evt_out[d].frame_start = frame_start_r;
            assign dir_evt_out[d].first_bit   = first_bit_r;
            assign dir_evt_out[d].sample      = sample_r;
            assign dir_cfg_out[d]             = c;
        end
    endgenerate

endmodule

// ==== tcfs_pkg.sv ====
// Package for the serial clock and frame sync selection front end
package tcfs_pkg;
    // Register word offsets (byte addresses)
    localparam logic [7:0] TCFS_OFS_GLOBAL = 8'h00;
    localparam logic [7:0] TCFS_OFS_RX_CLK = 8'h04;
    localparam logic [7:0] TCFS_OFS_TX_CLK = 8'h08;
    localparam logic [7:0] TCFS_OFS_RX_CFG = 8'h0C;
    localparam logic [7:0] TCFS_OFS_TX_CFG = 8'h10;
    localparam logic [7:0] TCFS_OFS_STATUS = 8'h14;

    // Global config fields
    localparam int TCFS_BIT_RX_EN  = 0;
    localparam int TCFS_BIT_TX_EN  = 1;
    localparam int TCFS_BIT_REDUND = 4;
    // Clock select field
    localparam int TCFS_BIT_SRC    = 0;
    // Channel config fields
    localparam int TCFS_BIT_MODE   = 0;
    localparam int TCFS_POS_RATE   = 1;
    localparam int TCFS_BIT_DPOL   = 3;
    localparam int TCFS_BIT_FPOL   = 4;
    localparam int TCFS_BIT_LEVEL  = 7;
    localparam int TCFS_POS_DELAY  = 16;
    localparam int TCFS_W_DELAY    = 14;

    // Reset values
    localparam logic [31:0] TCFS_RST_GLOBAL = 32'h0000_0000;
    localparam logic [31:0] TCFS_RST_CLKSEL = 32'h0000_0000;
    localparam logic [31:0] TCFS_RST_CHCFG  = 32'h0000_0000;

    // Writable bit masks
    localparam logic [31:0] TCFS_MSK_GLOBAL = 32'h0000_0013;
    localparam logic [31:0] TCFS_MSK_CLKSEL = 32'h0000_0001;
    localparam logic [31:0] TCFS_MSK_CHCFG  = 32'h3FFF_009F;
    localparam logic [31:0] TCFS_MSK_LOCKED = 32'h3FFF_0080;

    // Timing: serial clocks per default frame (128 timeslots of 8 bits)
    localparam int TCFS_FRAME_CLOCKS = 1024;
    localparam int TCFS_CNT_W        = 16;

    // Link rate codes
    typedef enum logic [1:0] {
        TCFS_RATE_8M  = 2'b00,
        TCFS_RATE_16M = 2'b01,
        TCFS_RATE_32M = 2'b10,
        TCFS_RATE_RSV = 2'b11
    } tcfs_rate_t;

    // Effective per-direction configuration
    typedef struct packed {
        logic                     source;     // 0 pair A, 1 pair B
        logic                     single;     // 1 single-rate clock
        tcfs_rate_t               rate;
        logic                     data_pol;   // 1 rising data edge
        logic                     sync_pol;   // 1 rising frame sync edge
        logic                     level;      // 1 frame sync active high
        logic [TCFS_W_DELAY-1:0]  delay;
    } tcfs_dir_cfg_t;

    // Per-direction timing events
    typedef struct packed {
        logic locked;        // Frame timing established
        logic frame_start;   // Frame sync accepted (pulse)
        logic first_bit;     // First bit edge of timeslot 0 (pulse)
        logic sample;        // Data sample edge (pulse)
    } tcfs_dir_evt_t;
endpackage

// ==== tcfs_checker_props.sv ====
// Checker for the clock and frame sync selection front end
module tcfs_checker
    import tcfs_pkg::*;
(
    input wire logic                core_clk_in,
    input wire logic                nrst_in,
    input wire logic [7:0]          reg_addr_in,
    input wire logic [31:0]         reg_wdata_in,
    input wire logic                reg_wr_in,
    input wire logic                reg_rd_in,
    input wire logic [31:0]         reg_rdata_out,
    input wire logic                serial_clock_a_in,
    input wire logic                frame_sync_a_in,
    input wire logic                serial_clock_b_in,
    input wire logic                frame_sync_b_in,
    input wire tcfs_dir_evt_t [1:0] dir_evt_out,
    input wire tcfs_dir_cfg_t [1:0] dir_cfg_out
);
    logic [1:0] en_r;
    logic       red_r;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    // Shadow of the enable and redundancy bits
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            en_r  <= 2'h0;
            red_r <= 1'b0;
        end
        else if (reg_wr_in && reg_addr_in == TCFS_OFS_GLOBAL)
        begin
            en_r  <= reg_wdata_in[1:0];
            red_r <= reg_wdata_in[TCFS_BIT_REDUND];
        end
    end

    // Register port and timing relations
    a_read_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > TCFS_OFS_STATUS
        |=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
    a_shared_cfg: assert property (!red_r |-> dir_cfg_out[0].source == dir_cfg_out[1].source
        && dir_cfg_out[0].single == dir_cfg_out[1].single
        && dir_cfg_out[0].rate == dir_cfg_out[1].rate) else $error("shared config differs");
    a_tx_cfg_locked: assert property (en_r[1] && reg_wr_in && reg_addr_in == TCFS_OFS_TX_CFG
        |=> $stable(dir_cfg_out[1].delay) && $stable(dir_cfg_out[1].level))
        else $error("tx config changed while enabled");
    a_rx_cfg_locked: assert property (en_r[0] && reg_wr_in && reg_addr_in == TCFS_OFS_RX_CFG
        |=> $stable(dir_cfg_out[0].delay) && $stable(dir_cfg_out[0].level))
        else $error("rx config changed while enabled");
    a_no_bit_at_sync: assert property (dir_evt_out[1].frame_start
        |-> (!dir_evt_out[1].first_bit) [*5]) else $error("first bit too close to sync");
    a_start_single: assert property (dir_evt_out[1].frame_start
        |=> (!dir_evt_out[1].frame_start) [*8]) else $error("frame start repeated");
    a_bit_when_locked: assert property (dir_evt_out[1].first_bit || dir_evt_out[1].sample
        |-> dir_evt_out[1].locked) else $error("tx bit event without lock");
    a_tx_lock_drop: assert property ((!en_r[1]) [*2] |-> !dir_evt_out[1].locked)
        else $error("tx lock kept while disabled");
    a_rx_lock_drop: assert property ((!en_r[0]) [*2] |-> !dir_evt_out[0].locked)
        else $error("rx lock kept while disabled");
endmodule

bind tcfs_clock_sync_select tcfs_checker u_chk (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .serial_clock_a_in(serial_clock_a_in),
    .frame_sync_a_in(frame_sync_a_in), .serial_clock_b_in(serial_clock_b_in),
    .frame_sync_b_in(frame_sync_b_in), .dir_evt_out(dir_evt_out), .dir_cfg_out(dir_cfg_out));

// ==== tcfs_backplane.sv ====
// Backplane model: one free running serial clock with its frame sync
module tcfs_backplane #(
    parameter int  FRAME = 1024,
    parameter time HALF  = 32,
    parameter time PHASE = 5
) (
    input  wire logic sync_en_in,
    input  wire logic extra_in,
    output logic      sclk_out,
    output logic      sync_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;

    // Clock starts at its own phase, then runs free
    initial
    begin
        sclk_out = 1'b0;
        sync_n_out = 1'b1;
        cnt = 0;
        #PHASE;
        forever #HALF sclk_out = ~sclk_out;
    end

    // Active low sync launched on the rising edge, one clock wide
    always @(posedge sclk_out)
    begin
        cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
        sync_n_out <= !((cnt == 0 && sync_en_in) || extra_in);
    end
endmodule

// ==== tb_top.sv ====
// Testbench for the clock and frame sync selection front end
module tb_top;
    import tcfs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic                clk = 1'b0;
    logic                nrst_n;
    logic [7:0]          addr;
    logic [31:0]         wdata;
    logic                wr;
    logic                rd;
    logic [31:0]         rdata;
    logic                clk_a, fs_a, clk_b, fs_b;
    logic                en_b;
    logic                extra;
    tcfs_dir_evt_t [1:0] evt;
    tcfs_dir_cfg_t [1:0] cfg;
    int                  num_errors = 0;
    int                  num_checks = 0;

    // Core clock, 8 ns period
    always #4 clk = ~clk;

    tcfs_clock_sync_select DUT (.core_clk_in(clk), .nrst_in(nrst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .serial_clock_a_in(clk_a), .frame_sync_a_in(fs_a), .serial_clock_b_in(clk_b),
        .frame_sync_b_in(fs_b), .dir_evt_out(evt), .dir_cfg_out(cfg));
    tcfs_backplane #(.PHASE(5)) pair_a (.sync_en_in(1'b1), .extra_in(extra),
        .sclk_out(clk_a), .sync_n_out(fs_a));
    tcfs_backplane #(.PHASE(19)) pair_b (.sync_en_in(en_b), .extra_in(extra),
        .sclk_out(clk_b), .sync_n_out(fs_b));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Timing compare with three core cycles of slack for the pin synchroniser
    task automatic chk_near(input string name, input int exp, input int got);
        num_checks++;
        if (got < exp - 24 || got > exp + 24)
        begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask

    // Waits for a tx frame start or first bit; n equals lim when none came
    task automatic wait_evt(input bit first, input int lim, output int n);
        for (n = 0; n < lim; n++)
        begin
            @(posedge clk);
            #1;
            if ((first ? evt[1].first_bit : evt[1].frame_start) === 1'b1)
                break;
        end
    endtask

    task automatic t_regs();
        for (int i = 0; i < 6; i++)
            rd_chk("reset value", 8'(4 * i), 32'h0);
        wr32(TCFS_OFS_RX_CFG, '1);
        wr32(TCFS_OFS_TX_CFG, '1);
        wr32(TCFS_OFS_RX_CLK, '1);
        wr32(TCFS_OFS_GLOBAL, '1);
        rd_chk("rx config", TCFS_OFS_RX_CFG, TCFS_MSK_CHCFG);
        rd_chk("tx config", TCFS_OFS_TX_CFG, TCFS_MSK_CHCFG);
        rd_chk("rx clock", TCFS_OFS_RX_CLK, TCFS_MSK_CLKSEL);
        rd_chk("global", TCFS_OFS_GLOBAL, TCFS_MSK_GLOBAL);
        wr32(TCFS_OFS_RX_CFG, 32'h0);
        wr32(TCFS_OFS_TX_CFG, 32'h0);
        rd_chk("rx held", TCFS_OFS_RX_CFG, TCFS_MSK_LOCKED);
        rd_chk("tx held", TCFS_OFS_TX_CFG, TCFS_MSK_LOCKED);
        wr32(8'h18, '1);
        rd_chk("unmapped", 8'h18, 32'h0);
        wr32(TCFS_OFS_GLOBAL, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_mux();
        for (int r = 0; r < 4; r++)
        begin
            wr32(TCFS_OFS_TX_CFG, 32'(2 * r + 1));
            wr32(TCFS_OFS_RX_CFG, 32'(6 - 2 * r));
            wr32(TCFS_OFS_RX_CLK, 32'h0);
            wr32(TCFS_OFS_TX_CLK, 32'h1);
            wr32(TCFS_OFS_GLOBAL, 32'h0);
            chk("shared rate", 32'(r), 32'(cfg[0].rate));
            chk("shared source", 32'h1, 32'(cfg[0].source));
            chk("shared mode", 32'h1, 32'(cfg[0].single));
            wr32(TCFS_OFS_GLOBAL, 32'h10);
            chk("own rate", 32'(3 - r), 32'(cfg[0].rate));
            chk("own source", 32'h0, 32'(cfg[0].source));
            chk("tx rate", 32'(r), 32'(cfg[1].rate));
        end
        $display("test selection done");
    endtask

    task automatic t_delay(input logic [31:0] c, input logic src, input int edges);
        int  n;
        time t0;
        wr32(TCFS_OFS_GLOBAL, 32'h10);
        wr32(TCFS_OFS_TX_CLK, 32'(src));
        wr32(TCFS_OFS_TX_CFG, c);
        wr32(TCFS_OFS_GLOBAL, 32'h12);
        wait_evt(1'b0, 9000, n);
        chk("frame start", 32'h1, 32'(n < 9000));
        chk("locked", 32'h1, 32'(evt[1].locked));
        t0 = $time;
        wait_evt(1'b1, 200, n);
        chk_near("first bit ns", edges * 32, int'($time - t0));
        $display("test delay done");
    endtask

    task automatic t_early();
        int n;
        repeat (100) @(posedge clk);
        extra <= 1'b1;
        repeat (8) @(posedge clk);
        extra <= 1'b0;
        wait_evt(1'b0, 200, n);
        chk("early sync", 32'd200, 32'(n));
        $display("test early sync done");
    endtask

    task automatic t_source();
        int n;
        en_b <= 1'b0;
        wr32(TCFS_OFS_GLOBAL, 32'h10);
        wr32(TCFS_OFS_TX_CLK, 32'h1);
        wr32(TCFS_OFS_GLOBAL, 32'h12);
        wait_evt(1'b0, 9000, n);
        chk("other pair", 32'd9000, 32'(n));
        en_b <= 1'b1;
        $display("test source done");
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        nrst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        en_b = 1'b1;
        extra = 1'b0;
        repeat (20) @(posedge clk);
        nrst_n <= 1'b1;
        t_regs();
        t_mux();
        t_delay(32'h0002_0001, 1'b0, 8);
        t_early();
        t_delay(32'h0002_0009, 1'b0, 7);
        t_delay(32'h0001_0000, 1'b0, 3);
        t_delay(32'h0001_0008, 1'b0, 4);
        t_source();
        t_delay(32'h0001_0000, 1'b1, 3);
        print_verdict();
    end

    // Watchdog
    initial
    begin
        #800_000;
        num_errors++;
        print_verdict();
    end
endmodule
